/* File: core/pieb_regs.svh */
// Register offsets, field positions and reset values of the peripheral interrupt enable bank.
// Assumes a 32-bit APB bus with byte addresses; each register takes one aligned word.
`ifndef PIEB_REGS_SVH
`define PIEB_REGS_SVH

`define PIEB_ADDR_W 8
`define PIEB_OFF_EN_A 8'h00
`define PIEB_OFF_EN_B 8'h04
`define PIEB_OFF_EN_C 8'h08
`define PIEB_OFF_FLAGS_A 8'h0c
`define PIEB_OFF_FLAGS_B 8'h10
`define PIEB_OFF_FLAGS_C 8'h14
`define PIEB_OFF_CORE_CTRL 8'h18
`define PIEB_OFF_STATUS 8'h1c

`define PIEB_MASK_EN_A 8'hff
`define PIEB_MASK_EN_B 8'hfd
`define PIEB_MASK_EN_C 8'h7a
`define PIEB_RST_EN 8'h00
`define PIEB_RST_FLAGS 8'h00
`define PIEB_RST_CTRL 2'h0

`define PIEB_BIT_GLOBAL_EN 1
`define PIEB_BIT_GROUP_EN 0
`define PIEB_BIT_REQ 0

// Source positions inside the enable and flag registers
`define PIEB_POS_TIMER1_GATE 7
`define PIEB_POS_ADC 6
`define PIEB_POS_SERIAL_RX 5
`define PIEB_POS_SERIAL_TX 4
`define PIEB_POS_SYNC_SERIAL 3
`define PIEB_POS_CAPCOMP1 2
`define PIEB_POS_TIMER2_MATCH 1
`define PIEB_POS_TIMER1_OVERFLOW 0
`define PIEB_POS_OSC_FAIL 7
`define PIEB_POS_COMPARATOR2 6
`define PIEB_POS_COMPARATOR1 5
`define PIEB_POS_EEPROM_DONE 4
`define PIEB_POS_BUS_COLLISION 3
`define PIEB_POS_LCD_MODULE 2
`define PIEB_POS_CAPCOMP2 0
`define PIEB_POS_CAPCOMP5 6
`define PIEB_POS_CAPCOMP4 5
`define PIEB_POS_CAPCOMP3 4
`define PIEB_POS_TIMER6_MATCH 3
`define PIEB_POS_TIMER4_MATCH 1

`endif

/* File: core/pieb_pkg.sv */
// Types shared by the peripheral interrupt enable bank.
// Assumes nothing beyond a SystemVerilog compiler.
package pieb_pkg;

	typedef logic [7:0] pieb_byte_t;

	typedef enum logic [1:0] {
		pieb_idle,
		pieb_access
	} pieb_phase_t;

	typedef enum logic [1:0] {
		pieb_bank_a,
		pieb_bank_b,
		pieb_bank_c
	} pieb_bank_t;

endpackage : pieb_pkg

/* File: core/pieb_flag_reg.sv */
// One 8-bit sticky flag register with write-one-to-clear.
// Assumes event inputs are synchronous pulses or levels on pclk.
`timescale 1ns/100ps
`include "pieb_regs.svh"
module pieb_flag_reg #(
	parameter logic [7:0] MASK = 8'hff
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and clear
	input wire logic [7:0] event_in,
	input wire logic [7:0] clear_in,
	// State
	output logic [7:0] flags
);

	logic [7:0] next_flags;

	// Set wins over clear; unimplemented positions stay zero
	always_comb begin
		next_flags = ((flags & ~clear_in) | event_in) & MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= `PIEB_RST_FLAGS;
		end else begin
			flags <= next_flags;
		end
	end

endmodule : pieb_flag_reg

/* File: core/pieb_enable_reg.sv */
// One 8-bit software enable register with masked implemented positions.
// Assumes write strobe and data come from the APB slave of the bank.
`timescale 1ns/100ps
`include "pieb_regs.svh"
module pieb_enable_reg #(
	parameter logic [7:0] MASK = 8'hff
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// State
	output logic [7:0] enables
);

	logic [7:0] next_enables;

	always_comb begin
		next_enables = enables;
		if (wr_en) begin
			next_enables = wr_data & MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables <= `PIEB_RST_EN;
		end else begin
			enables <= next_enables;
		end
	end

endmodule : pieb_enable_reg

/* File: core/pieb_bank.sv */
// Peripheral interrupt enable bank: three enable registers, three flag registers, core control, APB slave.
// Assumes a synchronous APB master on pclk and peripheral events synchronous to pclk.
//
// What this block does
// - No peripheral request without group enable set
// - Enable A bits 7-4: gate, adc, rx, tx
// - Enable A bits 3-0: sync serial, cc1, t2, t1
// - Enable B bits 7-4: osc, cmp2, cmp1, eeprom
// - Enable B bits 3,2,0: collision, lcd, cc2
// - Enable C bits 6-4: cc5, cc4, cc3
// - Enable C bit 3 timer6, bit 1 timer4
// - Unimplemented enable bits always read zero
// - Enable bits read/write, clear on any reset
// - Flags set regardless of any enable bit
// - Global enable off blocks cpu_irq, not periph_irq_req
// - Group enable off blocks peripheral sources
`timescale 1ns/100ps
`include "pieb_regs.svh"
module pieb_bank (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral event inputs
	input wire logic timer1_gate_evt,
	input wire logic adc_evt,
	input wire logic serial_rx_evt,
	input wire logic serial_tx_evt,
	input wire logic sync_serial_evt,
	input wire logic capcomp1_evt,
	input wire logic timer2_match_evt,
	input wire logic timer1_overflow_evt,
	input wire logic osc_fail_evt,
	input wire logic comparator2_evt,
	input wire logic comparator1_evt,
	input wire logic eeprom_write_done_evt,
	input wire logic bus_collision_evt,
	input wire logic lcd_module_evt,
	input wire logic capcomp2_evt,
	input wire logic capcomp5_evt,
	input wire logic capcomp4_evt,
	input wire logic capcomp3_evt,
	input wire logic timer6_match_evt,
	input wire logic timer4_match_evt,
	// Interrupt request toward the core
	output logic periph_irq_req,
	output logic cpu_irq
);

	// Address decode used by both read and write paths
	function automatic logic addr_hit(input logic [31:0] addr, input logic [`PIEB_ADDR_W-1:0] off);
		addr_hit = (addr[31:`PIEB_ADDR_W] == '0) && (addr[`PIEB_ADDR_W-1:0] == off);
	endfunction : addr_hit

	function automatic logic addr_known(input logic [31:0] addr);
		addr_known = addr_hit(addr, `PIEB_OFF_EN_A) || addr_hit(addr, `PIEB_OFF_EN_B) ||
			addr_hit(addr, `PIEB_OFF_EN_C) || addr_hit(addr, `PIEB_OFF_FLAGS_A) ||
			addr_hit(addr, `PIEB_OFF_FLAGS_B) || addr_hit(addr, `PIEB_OFF_FLAGS_C) ||
			addr_hit(addr, `PIEB_OFF_CORE_CTRL) || addr_hit(addr, `PIEB_OFF_STATUS);
	endfunction : addr_known

	logic wr_access;
	logic rd_access;
	logic wr_lane0;
	logic [7:0] wbyte;
	logic [7:0] periph_irq_enable_a;
	logic [7:0] periph_irq_enable_b;
	logic [7:0] periph_irq_enable_c;
	logic [7:0] periph_irq_flags_a;
	logic [7:0] periph_irq_flags_b;
	logic [7:0] periph_irq_flags_c;
	logic [7:0] evt_a;
	logic [7:0] evt_b;
	logic [7:0] evt_c;
	logic [7:0] clr_a;
	logic [7:0] clr_b;
	logic [7:0] clr_c;
	logic periph_group_enable;
	logic global_irq_enable;
	logic next_periph_group_enable;
	logic next_global_irq_enable;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic any_pending;
	logic next_periph_irq_req;
	logic next_cpu_irq;
	pieb_pkg::pieb_phase_t phase;
	pieb_pkg::pieb_phase_t next_phase;
	// Enable bit of each source
	logic timer1_gate_irq_en;
	logic adc_irq_en;
	logic serial_rx_irq_en;
	logic serial_tx_irq_en;
	logic sync_serial_irq_en;
	logic capcomp1_irq_en;
	logic timer2_match_irq_en;
	logic timer1_overflow_irq_en;
	logic osc_fail_irq_en;
	logic comparator2_irq_en;
	logic comparator1_irq_en;
	logic eeprom_write_done_irq_en;
	logic bus_collision_irq_en;
	logic lcd_module_irq_en;
	logic capcomp2_irq_en;
	logic capcomp5_irq_en;
	logic capcomp4_irq_en;
	logic capcomp3_irq_en;
	logic timer6_match_irq_en;
	logic timer4_match_irq_en;

	// Zero wait state slave; answer in the access cycle
	assign pready = 1'b1;
	assign wr_access = psel && penable && pwrite && (phase == pieb_pkg::pieb_access);
	assign rd_access = psel && !penable && !pwrite;
	assign wr_lane0 = wr_access && pstrb[0];
	assign wbyte = pwdata[7:0];

	// Event vectors in register bit order; unimplemented positions stay zero
	always_comb begin
		evt_a = 8'h00;
		evt_b = 8'h00;
		evt_c = 8'h00;
		evt_a[`PIEB_POS_TIMER1_GATE] = timer1_gate_evt;
		evt_a[`PIEB_POS_ADC] = adc_evt;
		evt_a[`PIEB_POS_SERIAL_RX] = serial_rx_evt;
		evt_a[`PIEB_POS_SERIAL_TX] = serial_tx_evt;
		evt_a[`PIEB_POS_SYNC_SERIAL] = sync_serial_evt;
		evt_a[`PIEB_POS_CAPCOMP1] = capcomp1_evt;
		evt_a[`PIEB_POS_TIMER2_MATCH] = timer2_match_evt;
		evt_a[`PIEB_POS_TIMER1_OVERFLOW] = timer1_overflow_evt;
		evt_b[`PIEB_POS_OSC_FAIL] = osc_fail_evt;
		evt_b[`PIEB_POS_COMPARATOR2] = comparator2_evt;
		evt_b[`PIEB_POS_COMPARATOR1] = comparator1_evt;
		evt_b[`PIEB_POS_EEPROM_DONE] = eeprom_write_done_evt;
		evt_b[`PIEB_POS_BUS_COLLISION] = bus_collision_evt;
		evt_b[`PIEB_POS_LCD_MODULE] = lcd_module_evt;
		evt_b[`PIEB_POS_CAPCOMP2] = capcomp2_evt;
		evt_c[`PIEB_POS_CAPCOMP5] = capcomp5_evt;
		evt_c[`PIEB_POS_CAPCOMP4] = capcomp4_evt;
		evt_c[`PIEB_POS_CAPCOMP3] = capcomp3_evt;
		evt_c[`PIEB_POS_TIMER6_MATCH] = timer6_match_evt;
		evt_c[`PIEB_POS_TIMER4_MATCH] = timer4_match_evt;
	end

	// Write one to clear the flag bits
	assign clr_a = (wr_lane0 && addr_hit(paddr, `PIEB_OFF_FLAGS_A)) ? wbyte : 8'h00;
	assign clr_b = (wr_lane0 && addr_hit(paddr, `PIEB_OFF_FLAGS_B)) ? wbyte : 8'h00;
	assign clr_c = (wr_lane0 && addr_hit(paddr, `PIEB_OFF_FLAGS_C)) ? wbyte : 8'h00;

	pieb_enable_reg #(.MASK(`PIEB_MASK_EN_A)) u_en_a (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_lane0 && addr_hit(paddr, `PIEB_OFF_EN_A)),
		.wr_data(wbyte),
		.enables(periph_irq_enable_a)
	);

	pieb_enable_reg #(.MASK(`PIEB_MASK_EN_B)) u_en_b (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_lane0 && addr_hit(paddr, `PIEB_OFF_EN_B)),
		.wr_data(wbyte),
		.enables(periph_irq_enable_b)
	);

	pieb_enable_reg #(.MASK(`PIEB_MASK_EN_C)) u_en_c (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_lane0 && addr_hit(paddr, `PIEB_OFF_EN_C)),
		.wr_data(wbyte),
		.enables(periph_irq_enable_c)
	);

	pieb_flag_reg #(.MASK(`PIEB_MASK_EN_A)) u_flags_a (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(evt_a),
		.clear_in(clr_a),
		.flags(periph_irq_flags_a)
	);

	pieb_flag_reg #(.MASK(`PIEB_MASK_EN_B)) u_flags_b (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(evt_b),
		.clear_in(clr_b),
		.flags(periph_irq_flags_b)
	);

	pieb_flag_reg #(.MASK(`PIEB_MASK_EN_C)) u_flags_c (
		.pclk(pclk),
		.presetn(presetn),
		.event_in(evt_c),
		.clear_in(clr_c),
		.flags(periph_irq_flags_c)
	);

	// Enable bit of each source, picked out of its register
	assign timer1_gate_irq_en = periph_irq_enable_a[`PIEB_POS_TIMER1_GATE];
	assign adc_irq_en = periph_irq_enable_a[`PIEB_POS_ADC];
	assign serial_rx_irq_en = periph_irq_enable_a[`PIEB_POS_SERIAL_RX];
	assign serial_tx_irq_en = periph_irq_enable_a[`PIEB_POS_SERIAL_TX];
	assign sync_serial_irq_en = periph_irq_enable_a[`PIEB_POS_SYNC_SERIAL];
	assign capcomp1_irq_en = periph_irq_enable_a[`PIEB_POS_CAPCOMP1];
	assign timer2_match_irq_en = periph_irq_enable_a[`PIEB_POS_TIMER2_MATCH];
	assign timer1_overflow_irq_en = periph_irq_enable_a[`PIEB_POS_TIMER1_OVERFLOW];
	assign osc_fail_irq_en = periph_irq_enable_b[`PIEB_POS_OSC_FAIL];
	assign comparator2_irq_en = periph_irq_enable_b[`PIEB_POS_COMPARATOR2];
	assign comparator1_irq_en = periph_irq_enable_b[`PIEB_POS_COMPARATOR1];
	assign eeprom_write_done_irq_en = periph_irq_enable_b[`PIEB_POS_EEPROM_DONE];
	assign bus_collision_irq_en = periph_irq_enable_b[`PIEB_POS_BUS_COLLISION];
	assign lcd_module_irq_en = periph_irq_enable_b[`PIEB_POS_LCD_MODULE];
	assign capcomp2_irq_en = periph_irq_enable_b[`PIEB_POS_CAPCOMP2];
	assign capcomp5_irq_en = periph_irq_enable_c[`PIEB_POS_CAPCOMP5];
	assign capcomp4_irq_en = periph_irq_enable_c[`PIEB_POS_CAPCOMP4];
	assign capcomp3_irq_en = periph_irq_enable_c[`PIEB_POS_CAPCOMP3];
	assign timer6_match_irq_en = periph_irq_enable_c[`PIEB_POS_TIMER6_MATCH];
	assign timer4_match_irq_en = periph_irq_enable_c[`PIEB_POS_TIMER4_MATCH];

	// Core control: group and global enables
	always_comb begin
		next_periph_group_enable = periph_group_enable;
		next_global_irq_enable = global_irq_enable;
		if (wr_lane0 && addr_hit(paddr, `PIEB_OFF_CORE_CTRL)) begin
			next_periph_group_enable = wbyte[`PIEB_BIT_GROUP_EN];
			next_global_irq_enable = wbyte[`PIEB_BIT_GLOBAL_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{global_irq_enable, periph_group_enable} <= `PIEB_RST_CTRL;
		end else begin
			periph_group_enable <= next_periph_group_enable;
			global_irq_enable <= next_global_irq_enable;
		end
	end

	// Request generation
	always_comb begin
		any_pending = (periph_irq_flags_a[`PIEB_POS_TIMER1_GATE] && timer1_gate_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_ADC] && adc_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_SERIAL_RX] && serial_rx_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_SERIAL_TX] && serial_tx_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_SYNC_SERIAL] && sync_serial_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_CAPCOMP1] && capcomp1_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_TIMER2_MATCH] && timer2_match_irq_en) ||
			(periph_irq_flags_a[`PIEB_POS_TIMER1_OVERFLOW] && timer1_overflow_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_OSC_FAIL] && osc_fail_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_COMPARATOR2] && comparator2_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_COMPARATOR1] && comparator1_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_EEPROM_DONE] && eeprom_write_done_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_BUS_COLLISION] && bus_collision_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_LCD_MODULE] && lcd_module_irq_en) ||
			(periph_irq_flags_b[`PIEB_POS_CAPCOMP2] && capcomp2_irq_en) ||
			(periph_irq_flags_c[`PIEB_POS_CAPCOMP5] && capcomp5_irq_en) ||
			(periph_irq_flags_c[`PIEB_POS_CAPCOMP4] && capcomp4_irq_en) ||
			(periph_irq_flags_c[`PIEB_POS_CAPCOMP3] && capcomp3_irq_en) ||
			(periph_irq_flags_c[`PIEB_POS_TIMER6_MATCH] && timer6_match_irq_en) ||
			(periph_irq_flags_c[`PIEB_POS_TIMER4_MATCH] && timer4_match_irq_en);
		next_periph_irq_req = any_pending && periph_group_enable;
		next_cpu_irq = next_periph_irq_req && global_irq_enable;
	end

	// Read data captured in setup cycle, valid during access
	always_comb begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		next_phase = pieb_pkg::pieb_idle;
		if (psel && !penable) begin
			next_phase = pieb_pkg::pieb_access;
			next_pslverr = !addr_known(paddr);
			next_prdata = 32'h0000_0000;
		end
		if (rd_access) begin
			case (paddr[`PIEB_ADDR_W-1:0])
				`PIEB_OFF_EN_A: next_prdata = {24'h00_0000, periph_irq_enable_a};
				`PIEB_OFF_EN_B: next_prdata = {24'h00_0000, periph_irq_enable_b};
				`PIEB_OFF_EN_C: next_prdata = {24'h00_0000, periph_irq_enable_c};
				`PIEB_OFF_FLAGS_A: next_prdata = {24'h00_0000, periph_irq_flags_a};
				`PIEB_OFF_FLAGS_B: next_prdata = {24'h00_0000, periph_irq_flags_b};
				`PIEB_OFF_FLAGS_C: next_prdata = {24'h00_0000, periph_irq_flags_c};
				`PIEB_OFF_CORE_CTRL: next_prdata = {30'h0000_0000, global_irq_enable, periph_group_enable};
				`PIEB_OFF_STATUS: next_prdata = {31'h0000_0000, periph_irq_req};
				default: next_prdata = 32'h0000_0000;
			endcase
			if (paddr[31:`PIEB_ADDR_W] != '0) begin
				next_prdata = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			phase <= pieb_pkg::pieb_idle;
			periph_irq_req <= 1'b0;
			cpu_irq <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			phase <= next_phase;
			periph_irq_req <= next_periph_irq_req;
			cpu_irq <= next_cpu_irq;
		end
	end

endmodule : pieb_bank

/* File: testbench/pieb_bank_checker.sv */
// Port checks of the peripheral interrupt enable bank.
// Assumes one clock pclk and reset presetn, asynchronous, active low.
`timescale 1ns/100ps
module pieb_bank_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Requests
	input wire logic periph_irq_req,
	input wire logic cpu_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup, wr, bad;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign bad = (paddr > 32'h1c) | (paddr[1:0] != 2'h0);
	// Requests only drop after a register write
	sequence wrote;
		$past(wr) || $past(wr, 2);
	endsequence
	sequence quiet;
		!periph_irq_req && !cpu_irq;
	endsequence
	a_err_access_only: assert property (pslverr |-> psel && penable)
		else $error("stray error");
	a_err_on_unmapped: assert property (setup |=> pslverr == $past(bad))
		else $error("error flag wrong");
	a_upper_read_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	a_rdata_holds: assert property (!$past(setup) |-> $stable(prdata))
		else $error("read data moved");
	a_reset_quiet: assert property ($rose(presetn) |-> quiet [*3])
		else $error("request after reset");
	a_cpu_needs_group: assert property (cpu_irq |-> periph_irq_req)
		else $error("cpu request alone");
	a_req_fall_write: assert property ($fell(periph_irq_req) |-> wrote)
		else $error("request dropped");
	a_cpu_fall_write: assert property ($fell(cpu_irq) |-> wrote)
		else $error("cpu request dropped");
endmodule : pieb_bank_checker
bind pieb_bank pieb_bank_checker pieb_bank_checker_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .periph_irq_req(periph_irq_req),
	.cpu_irq(cpu_irq));

/* File: testbench/pieb_periph_src.sv */
// Peripheral event source model: one event pulse per fire request, one cycle late.
// Assumes fire changes just after rising edges of pclk.
`timescale 1ns/100ps
module pieb_periph_src (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requests and events
	input wire logic [19:0] fire,
	output logic [19:0] evt
);
	logic [19:0] next_evt;
	always_comb begin
		next_evt = fire;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt <= 20'h0;
		end else begin
			evt <= next_evt;
		end
	end
endmodule : pieb_periph_src

/* File: testbench/pieb_bank_bench.sv */
// Bench of the peripheral interrupt enable bank: registers, events, request gating.
// Assumes the bank, its checker and the event source model.
`timescale 1ns/100ps
module pieb_bank_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [19:0] fire = 20'h0;
	logic [3:0] pstrb = 4'hf;
	logic [19:0] evt;
	logic [31:0] prdata, rd, d, a, b;
	logic pready, pslverr, err, req, cpu;
	int errors = 0;
	int n_compared = 0;
	int seed = 62756;
	int cycles = 0;
	always #12.5 pclk = ~pclk;
	pieb_periph_src pieb_periph_src_i(.pclk(pclk), .presetn(presetn), .fire(fire), .evt(evt));
	pieb_bank pieb_bank_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer1_gate_evt(evt[0]), .adc_evt(evt[1]), .serial_rx_evt(evt[2]), .serial_tx_evt(evt[3]),
		.sync_serial_evt(evt[4]), .capcomp1_evt(evt[5]), .timer2_match_evt(evt[6]), .timer1_overflow_evt(evt[7]),
		.osc_fail_evt(evt[8]), .comparator2_evt(evt[9]), .comparator1_evt(evt[10]),
		.eeprom_write_done_evt(evt[11]), .bus_collision_evt(evt[12]), .lcd_module_evt(evt[13]),
		.capcomp2_evt(evt[14]), .capcomp5_evt(evt[15]), .capcomp4_evt(evt[16]), .capcomp3_evt(evt[17]),
		.timer6_match_evt(evt[18]), .timer4_match_evt(evt[19]), .periph_irq_req(req), .cpu_irq(cpu));
	function automatic logic [7:0] msk(input int r);
		return (r == 0) ? 8'hff : (r == 1) ? 8'hfd : 8'h7a;
	endfunction : msk
	function automatic int reg_of(input int i);
		return (i < 8) ? 0 : (i < 15) ? 1 : 2;
	endfunction : reg_of
	function automatic logic [7:0] bit_of(input int i);
		return 8'h1 << ((i < 8) ? 7 - i : (i < 14) ? 15 - i : (i == 14) ? 0 : (i < 19) ? 21 - i : 1);
	endfunction : bit_of
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic apb(input logic w, input logic [31:0] adr, input logic [31:0] dat);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= adr;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic irq(input logic r, input logic c);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check(req, r);
		check(cpu, c);
	endtask : irq
	task automatic report_and_stop;
		$display("compared %0d, wrong %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			apb(1'b0, 32'(r * 4), 32'h0);
			check(rd, 32'h0);
			apb(1'b1, 32'(r * 4), 32'hff);
			apb(1'b0, 32'(r * 4), 32'h0);
			check(rd, {24'h0, msk(r)});
			d = $random(seed);
			apb(1'b1, 32'(r * 4), d);
			apb(1'b0, 32'(r * 4), 32'h0);
			check(rd, {24'h0, d[7:0] & msk(r)});
			// Write without byte lane 0 leaves the register alone
			pstrb <= 4'he;
			apb(1'b1, 32'(r * 4), ~d);
			pstrb <= 4'hf;
			apb(1'b0, 32'(r * 4), 32'h0);
			check(rd, {24'h0, d[7:0] & msk(r)});
		end
		apb(1'b0, 32'h24, 32'h0);
		check(err, 32'h1);
		// Reset in mid-run clears what was written
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			apb(1'b0, 32'(r * 4), 32'h0);
			check(rd, 32'h0);
		end
		$display("register test done");
		apb(1'b1, 32'h18, 32'h3);
		apb(1'b0, 32'h18, 32'h0);
		check(rd, 32'h3);
		for (int i = 0; i < 20; i++) begin
			a = 32'(reg_of(i) * 4);
			b = {24'h0, bit_of(i)};
			@(posedge pclk);
			fire <= 20'(1 << i);
			@(posedge pclk);
			fire <= 20'h0;
			apb(1'b0, a + 32'hc, 32'h0);
			check(rd, b);
			irq(1'b0, 1'b0);
			apb(1'b1, a, b);
			irq(1'b1, 1'b1);
			apb(1'b0, 32'h1c, 32'h0);
			check(rd, 32'h1);
			apb(1'b1, 32'h18, 32'h1);
			irq(1'b1, 1'b0);
			apb(1'b1, 32'h18, 32'h2);
			irq(1'b0, 1'b0);
			apb(1'b1, 32'h18, 32'h3);
			apb(1'b1, a + 32'hc, b);
			irq(1'b0, 1'b0);
			apb(1'b1, a, 32'h0);
		end
		$display("event test done");
		report_and_stop();
	end
endmodule : pieb_bank_bench
